// >>> rtl/scf_defs.svh
// Register map, field positions and constants of the sync framer
`ifndef SCF_DEFS_SVH
`define SCF_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCF_A_CTRL   8'h00
`define SCF_A_SYNC   8'h04
`define SCF_A_CMD    8'h08
`define SCF_A_TXD    8'h0c
`define SCF_A_RXD    8'h10
`define SCF_A_STAT   8'h14
`define SCF_A_XCHR   8'h18
`define SCF_A_BCNT   8'h1c
// ----------------------------------------
// Control fields
// ----------------------------------------
`define SCF_C_RAC    0
`define SCF_C_INBAND_FLOW_ENABLE   1
`define SCF_C_ICTS   2
`define SCF_C_ARTS   3
`define SCF_C_SRTS   4
`define SCF_C_PARITY_ENABLE_BIT   5
`define SCF_C_PAR    7:6
`define SCF_C_CHL    9:8
`define SCF_C_SYN8   10
`define SCF_C_DSYN   11
`define SCF_C_SYNC_LOAD_OPTION  12
`define SCF_C_CRC_APPEND_BIT   13
`define SCF_C_CCITT  14
`define SCF_C_PSET   15
`define SCF_C_FIDLE  16
`define SCF_C_PREN   17
`define SCF_C_PRCNT  21:18
`define SCF_C_DMA    22
`define SCF_C_CDAS   23
`define SCF_C_TCDE   24
// ----------------------------------------
// Command bits, constants
// ----------------------------------------
`define SCF_K_HUNT   0
`define SCF_K_RECEIVER_RESET_COMMAND   1
`define SCF_K_XF     2
`define SCF_K_XME    3
`define SCF_RTS_THR  6'd28
`define SCF_SH_DEPTH 32
`define SCF_POLY16   16'ha001
`define SCF_POLYCC   16'h8408
`endif

// >>> rtl/scf_pkg.sv
// Types shared by the sync framer
package scf_pkg;
	typedef enum logic [2:0] {
		SCF_TX_IDLE = 3'b000,
		SCF_TX_PRE  = 3'b001,
		SCF_TX_SYNC = 3'b011,
		SCF_TX_DATA = 3'b010,
		SCF_TX_CRC  = 3'b110
	} scf_tx_e;
	typedef enum logic [1:0] {
		SCF_RX_OFF  = 2'b00,
		SCF_RX_HUNT = 2'b01,
		SCF_RX_DATA = 2'b11,
		SCF_RX_WAIT = 2'b10
	} scf_rx_e;
endpackage

// >>> rtl/scf_framer.sv
// Character sync framer with modem-line flow control, APB slave
// Operation
// - Transmit only with clear-to-send low and, if in-band enabled, XON state
// - Ignore-clear-to-send bit lets transmit regardless; XON/XOFF still works
// - Auto RTS active when auto bit is 1 and software RTS bit 0
// - Shadow FIFO at 28 bytes drives RTS high
// - Shadow FIFO empty drives RTS low again
// - Shadow data moves to host FIFO whenever it has room; four bytes headroom
// - Clear-to-send loss stops transmit after current character
// - One or two sync characters, each 6 or 8 bits
// - Data character length 5 to 8 bits
// - Optional parity: even, odd, mark or space
// - Hunt command: watch for sync, store nothing
// - Sync found: flag it, store following characters LSB first
// - With equal character (data plus parity) and sync lengths, characters matching the first sync not stored unless sync-load set
// - Reception stops on disable, carrier loss, hunt, reset, termination
// - Disable waits for enable; hunt or reset hunts; termination needs hunt
// - Frame command sends sync then data until message end or count
// - Parity only on data characters
// - Optional 16 bit CRC, two polynomials, preset, sync excluded
// - Interframe fill of sync or idle after a frame
// - Underrun flags and inserts sync outside frame and CRC
// - Preamble pattern sent a chosen number of times before frame
// - XOFF halts after current character, XON resumes
`timescale 1ns/1ps
`include "scf_defs.svh"
module scf_framer
	import scf_pkg::*;
#(
	parameter int BIT_DIV = 8,
	parameter int HD      = 8
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	input  wire logic        cts_n,
	input  wire logic        carrier_detect_input_n,
	output logic             rts_n
);
	localparam int SD = `SCF_SH_DEPTH;
	localparam int SW = $clog2(SD);
	localparam int HW = $clog2(HD);
	typedef struct packed {
		logic [31:0]         ctrl;
		logic [31:0]         syn;
		logic [15:0]         xchr;
		logic [15:0]         bcnt;
		logic [7:0]          tbuf;
		logic                tfull;
		logic                xf_p;
		logic                xme_p;
		scf_tx_e             ts;
		logic [3:0]          pre_n;
		logic                sync2;
		logic [8:0]          sh;
		logic [3:0]          left;
		logic                txd;
		logic [15:0]         crc;
		scf_rx_e             rs;
		logic [15:0]         win;
		logic [3:0]          rcnt;
		logic                xon;
		logic [SD-1:0][7:0]  sm;
		logic [SW-1:0]       swp;
		logic [SW-1:0]       srp;
		logic [SW:0]         scnt;
		logic [HD-1:0][7:0]  hm;
		logic [HW-1:0]       hwp;
		logic [HW-1:0]       hrp;
		logic [HW:0]         hcnt;
		logic [1:0]          cts_s;
		logic [1:0]          cd_s;
		logic [1:0]          rxd_s;
		logic [7:0]          div;
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
		logic                sync_detected_interrupt;
		logic                udr;
		logic                ovf;
		logic                rts_n;
	} scf_st_s;
	scf_st_s     s;
	scf_st_s     n;
	logic        tick;
	logic        acc;
	logic        txok;
	logic        cdok;
	logic        push;
	logic        cmdw;
	logic [3:0]  dlen;
	logic [3:0]  plen;
	logic [3:0]  slen;
	logic [7:0]  chr;
	logic [7:0]  dch;
	logic [15:0] w;
	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [7:0] mk(input logic [3:0] l);
		mk = 8'hff >> (4'd8 - l);
	endfunction
	function automatic logic [8:0] with_par(input logic [7:0] d, input logic [3:0] l,
		input logic en, input logic [1:0] ty);
		logic p;
		p = ^(d & mk(l));
		case (ty)
			2'd0: p = p;
			2'd1: p = ~p;
			2'd2: p = 1'b1;
			default: p = 1'b0;
		endcase
		with_par = {1'b0, d & mk(l)};
		if (en) begin
			with_par[l] = p;
		end
	endfunction
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d,
		input logic [3:0] l, input logic cc);
		logic fb;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(l)) begin
				fb = c[0] ^ d[i];
				c = c >> 1;
				if (fb) begin
					c = c ^ (cc ? `SCF_POLYCC : `SCF_POLY16);
				end
			end
		end
		crc_upd = c;
	endfunction
	function automatic logic [7:0] top(input logic [15:0] v, input logic [3:0] l);
		top = 8'(v >> (5'd16 - {1'b0, l}));
	endfunction
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		tick = (s.div == 8'h00);
		acc = psel & penable & s.pready;
		cmdw = acc & pwrite & (paddr == `SCF_A_CMD);
		n.div = tick ? 8'(BIT_DIV - 1) : s.div - 8'h01;
		n.cts_s = {s.cts_s[0], cts_n};
		n.cd_s = {s.cd_s[0], carrier_detect_input_n};
		n.rxd_s = {s.rxd_s[0], rxd};
		dlen = {2'b00, s.ctrl[`SCF_C_CHL]} + 4'd5;
		plen = dlen + {3'b000, s.ctrl[`SCF_C_PARITY_ENABLE_BIT]};
		slen = s.ctrl[`SCF_C_SYN8] ? 4'd8 : 4'd6;
		cdok = ~s.ctrl[`SCF_C_CDAS] | ~s.cd_s[1];
		txok = (s.ctrl[`SCF_C_ICTS] | ~s.cts_s[1]) & (~s.ctrl[`SCF_C_INBAND_FLOW_ENABLE] | s.xon);
		push = 1'b0;
		w = {s.rxd_s[1], s.win[15:1]};
		chr = top(w, plen);
		dch = chr & mk(dlen);
		// ---- APB slave ----
		n.pready = psel & penable & ~s.pready;
		if (psel & penable & ~s.pready) begin
			n.pslverr = 1'b0;
			if (paddr == `SCF_A_CTRL) begin
				n.prdata = s.ctrl;
			end else if (paddr == `SCF_A_SYNC) begin
				n.prdata = s.syn;
			end else if (paddr == `SCF_A_XCHR) begin
				n.prdata = {16'h0000, s.xchr};
			end else if (paddr == `SCF_A_BCNT) begin
				n.prdata = {16'h0000, s.bcnt};
			end else if (paddr == `SCF_A_RXD) begin
				n.prdata = {23'h0, s.hcnt == '0, s.hm[s.hrp]};
			end else if (paddr == `SCF_A_STAT) begin
				n.prdata = {11'h000, 6'(s.scnt), 4'(s.hcnt), s.rs, s.ts, ~s.rts_n,
					s.xon, s.tfull, s.ovf, s.udr, s.sync_detected_interrupt};
			end else if (paddr == `SCF_A_CMD || paddr == `SCF_A_TXD) begin
				n.prdata = 32'h0;
			end else begin
				n.prdata = 32'h0;
				n.pslverr = 1'b1;
			end
		end
		if (acc & pwrite) begin
			if (paddr == `SCF_A_CTRL) begin
				n.ctrl = {7'h0, pwdata[24:0]};
			end else if (paddr == `SCF_A_SYNC) begin
				n.syn = pwdata;
			end else if (paddr == `SCF_A_XCHR) begin
				n.xchr = pwdata[15:0];
			end else if (paddr == `SCF_A_BCNT) begin
				n.bcnt = pwdata[15:0];
			end else if (paddr == `SCF_A_TXD && !s.tfull) begin
				n.tbuf = pwdata[7:0];
				n.tfull = 1'b1;
			end else if (paddr == `SCF_A_STAT) begin
				n.sync_detected_interrupt = s.sync_detected_interrupt & ~pwdata[0];
				n.udr = s.udr & ~pwdata[1];
				n.ovf = s.ovf & ~pwdata[2];
			end else if (paddr == `SCF_A_CMD) begin
				n.xf_p = s.xf_p | pwdata[`SCF_K_XF];
				n.xme_p = s.xme_p | pwdata[`SCF_K_XME];
			end
		end
		// ---- Transmit ----
		if (tick && s.left != 4'd0) begin
			n.txd = s.sh[0];
			n.sh = s.sh >> 1;
			n.left = s.left - 4'd1;
		end else if (tick) begin
			n.txd = 1'b1;
			if (txok) begin
				case (s.ts)
					SCF_TX_IDLE: begin
						if (s.xf_p) begin
							n.xf_p = cmdw & pwdata[`SCF_K_XF];
							n.sync2 = 1'b0;
							n.crc = {16{s.ctrl[`SCF_C_PSET]}};
							n.pre_n = s.ctrl[`SCF_C_PRCNT];
							n.ts = (s.ctrl[`SCF_C_PREN] && n.pre_n != 4'd0) ?
								SCF_TX_PRE : SCF_TX_SYNC;
						end else if (!s.ctrl[`SCF_C_FIDLE]) begin
							n.txd = s.syn[0];
							n.sh = {1'b0, s.syn[7:0] >> 1};
							n.left = slen - 4'd1;
						end
					end
					SCF_TX_PRE: begin
						n.txd = s.syn[16];
						n.sh = {1'b0, s.syn[23:16] >> 1};
						n.left = 4'd7;
						n.pre_n = s.pre_n - 4'd1;
						if (s.pre_n == 4'd1) begin
							n.ts = SCF_TX_SYNC;
						end
					end
					SCF_TX_SYNC: begin
						n.sh = {1'b0, (s.sync2 ? s.syn[15:8] : s.syn[7:0]) >> 1};
						n.txd = s.sync2 ? s.syn[8] : s.syn[0];
						n.left = slen - 4'd1;
						n.sync2 = 1'b1;
						if (s.sync2 || !s.ctrl[`SCF_C_DSYN]) begin
							n.ts = SCF_TX_DATA;
						end
					end
					SCF_TX_DATA: begin
						if (s.tfull) begin
							n.sh = with_par(s.tbuf, dlen, s.ctrl[`SCF_C_PARITY_ENABLE_BIT],
								s.ctrl[`SCF_C_PAR]) >> 1;
							n.txd = s.tbuf[0];
							n.left = plen - 4'd1;
							n.tfull = 1'b0;
							n.crc = crc_upd(s.crc, s.tbuf, dlen, s.ctrl[`SCF_C_CCITT]);
							n.bcnt = s.bcnt - 16'h0001;
							if (s.ctrl[`SCF_C_DMA] && s.bcnt == 16'h0001) begin
								n.xme_p = 1'b1;
							end
						end else if (s.xme_p) begin
							n.xme_p = cmdw & pwdata[`SCF_K_XME];
							n.ts = SCF_TX_IDLE;
							if (s.ctrl[`SCF_C_CRC_APPEND_BIT]) begin
								n.ts = SCF_TX_CRC;
								n.txd = s.crc[0];
								n.sh = {1'b0, s.crc[7:0] >> 1};
								n.left = 4'd7;
							end
						end else begin
							n.udr = 1'b1;
							n.txd = s.syn[0];
							n.sh = {1'b0, s.syn[7:0] >> 1};
							n.left = slen - 4'd1;
						end
					end
					default: begin
						n.txd = s.crc[8];
						n.sh = {1'b0, s.crc[15:8] >> 1};
						n.left = 4'd7;
						n.ts = SCF_TX_IDLE;
					end
				endcase
			end
		end
		// ---- Receive ----
		if (tick) begin
			n.win = w;
			case (s.rs)
				SCF_RX_OFF: begin
					if (s.ctrl[`SCF_C_RAC] && cdok) begin
						n.rs = SCF_RX_HUNT;
					end
				end
				SCF_RX_HUNT: begin
					if (s.ctrl[`SCF_C_DSYN] ? (top(w, slen) == (s.syn[15:8] & mk(slen)) &&
						top(w << slen, slen) == (s.syn[7:0] & mk(slen))) :
						top(w, slen) == (s.syn[7:0] & mk(slen))) begin
						n.rs = SCF_RX_DATA;
						n.sync_detected_interrupt = 1'b1;
						n.rcnt = 4'd0;
					end
				end
				SCF_RX_DATA: begin
					n.rcnt = s.rcnt + 4'd1;
					if (n.rcnt == plen) begin
						n.rcnt = 4'd0;
						push = s.ctrl[`SCF_C_SYNC_LOAD_OPTION] || plen != slen ||
							chr != (s.syn[7:0] & mk(slen));
						if (dch == (s.xchr[7:0] & mk(dlen))) begin
							n.xon = 1'b1;
						end else if (dch == (s.xchr[15:8] & mk(dlen))) begin
							n.xon = 1'b0;
						end
						if (s.ctrl[`SCF_C_TCDE] && dch == (s.syn[31:24] & mk(dlen))) begin
							n.rs = SCF_RX_WAIT;
						end
					end
				end
				default: begin
					n.rs = SCF_RX_WAIT;
				end
			endcase
		end
		if (!s.ctrl[`SCF_C_INBAND_FLOW_ENABLE]) begin
			n.xon = 1'b1;
		end
		// ---- FIFOs ----
		if (push && s.scnt != (SW+1)'(SD)) begin
			n.sm[s.swp] = dch;
			n.swp = s.swp + 1'b1;
			n.scnt = n.scnt + 1'b1;
		end else if (push) begin
			n.ovf = 1'b1;
		end
		if (s.scnt != '0 && s.hcnt != (HW+1)'(HD)) begin
			n.hm[s.hwp] = s.sm[s.srp];
			n.hwp = s.hwp + 1'b1;
			n.hcnt = n.hcnt + 1'b1;
			n.srp = s.srp + 1'b1;
			n.scnt = n.scnt - 1'b1;
		end
		if (psel && penable && !s.pready && !pwrite && paddr == `SCF_A_RXD &&
			s.hcnt != '0) begin
			n.hrp = s.hrp + 1'b1;
			n.hcnt = n.hcnt - 1'b1;
		end
		if (acc && pwrite && paddr == `SCF_A_CMD &&
			(pwdata[`SCF_K_HUNT] || pwdata[`SCF_K_RECEIVER_RESET_COMMAND])) begin
			n.rs = SCF_RX_HUNT;
			n.rcnt = 4'd0;
			if (pwdata[`SCF_K_RECEIVER_RESET_COMMAND]) begin
				n.swp = '0;
				n.srp = '0;
				n.scnt = '0;
				n.hwp = '0;
				n.hrp = '0;
				n.hcnt = '0;
			end
		end
		if (!s.ctrl[`SCF_C_RAC] || !cdok) begin
			n.rs = SCF_RX_OFF;
		end
		if (s.ctrl[`SCF_C_ARTS] && !s.ctrl[`SCF_C_SRTS]) begin
			if (s.scnt >= `SCF_RTS_THR) begin
				n.rts_n = 1'b1;
			end else if (s.scnt == '0) begin
				n.rts_n = 1'b0;
			end
		end else begin
			n.rts_n = ~s.ctrl[`SCF_C_SRTS];
		end
		if (sys_rst) begin
			n = '0;
			n.txd = 1'b1;
			n.rts_n = 1'b1;
			n.xon = 1'b1;
			n.cts_s = 2'b11;
			n.cd_s = 2'b11;
			n.rxd_s = 2'b11;
			n.win = '1;
		end
	end
	always_ff @(posedge sys_clk) begin
		s <= n;
	end
	assign txd = s.txd;
	assign rts_n = s.rts_n;
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic afl;
	assign afl = s.ctrl[`SCF_C_ARTS] & ~s.ctrl[`SCF_C_SRTS];
	property p_rts_hi;
		afl && s.scnt >= `SCF_RTS_THR && $stable(s.ctrl) |=> rts_n;
	endproperty
	a_rts_hi: assert property (p_rts_hi) else $error("RTS not raised");
	property p_rts_lo;
		afl && s.scnt == '0 && $stable(s.ctrl) |=> !rts_n;
	endproperty
	a_rts_lo: assert property (p_rts_lo) else $error("RTS not lowered");
	property p_cts_gate;
		tick && s.left == 4'd0 && s.cts_s[1] && !s.ctrl[`SCF_C_ICTS] |=> txd && s.left == 4'd0;
	endproperty
	a_cts_gate: assert property (p_cts_gate) else $error("Sent with CTS high");
	property p_ign;
		tick && s.left == 4'd0 && txok && s.ts == SCF_TX_SYNC |=> s.left != 4'd0;
	endproperty
	a_ign: assert property (p_ign) else $error("Sync not sent");
	sequence s_hit;
		s.rs == SCF_RX_HUNT ##1 s.rs == SCF_RX_DATA;
	endsequence
	property p_scd;
		s_hit |-> s.sync_detected_interrupt;
	endproperty
	a_scd: assert property (p_scd) else $error("Sync flag missing");
	property p_xoff;
		tick && s.left == 4'd0 && s.ctrl[`SCF_C_INBAND_FLOW_ENABLE] && !s.xon |=> txd ##1 s.left == 4'd0;
	endproperty
	a_xoff: assert property (p_xoff) else $error("Sent in XOFF");
	property p_move;
		s.scnt != '0 && s.hcnt == '0 && !(acc && pwrite) |=> s.hcnt == 1;
	endproperty
	a_move: assert property (p_move) else $error("No shadow move");
	property p_stop;
		!s.ctrl[`SCF_C_RAC] |=> s.rs == SCF_RX_OFF;
	endproperty
	a_stop: assert property (p_stop) else $error("Receiver still on");
	property p_udr;
		tick && s.left == 4'd0 && txok && s.ts == SCF_TX_DATA && !s.tfull && !s.xme_p
			|=> s.udr && s.crc == $past(s.crc);
	endproperty
	a_udr: assert property (p_udr) else $error("Underrun missed");
endmodule

// >>> testbench/scf_station.sv
// Remote station model: receive-line driver and clear-to-send source
`timescale 1ns/1ps
module scf_station #(
	parameter int BIT_DIV = 2
) (
	input  wire logic sys_clk,
	input  wire logic rts_n,
	input  wire logic halt,
	output logic      rxd,
	output logic      cts_n
);
	// ----------------------------------------
	// Handshake
	// ----------------------------------------
	// CTS follows halt
	assign cts_n = halt;

	initial begin
		rxd = 1'b1;
	end

	// ----------------------------------------
	// Character sender
	// ----------------------------------------
	// whole chars, LSB first, only while RTS low
	task automatic send_char(input logic [7:0] c, output logic sent);
		sent = (rts_n === 1'b0);
		if (sent) begin
			for (int i = 0; i < 8; i++) begin
				@(posedge sys_clk);
				rxd <= c[i];
				repeat (BIT_DIV - 1) @(posedge sys_clk);
			end
		end else begin
			@(posedge sys_clk);
			rxd <= 1'b1;
		end
	endtask
endmodule

// >>> testbench/test_sync_char_framer_with_flow_control.sv
// Self-checking bench of the sync framer
`timescale 1ns/1ps
`include "scf_defs.svh"
module test_sync_char_framer_with_flow_control;
	logic        sys_clk;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        cts_n;
	logic        cd_n;
	logic        rts_n;
	logic        halt;
	logic [31:0] rd;
	logic        err;
	logic        ph;
	logic [23:0] win;
	logic        hit;
	logic        s;
	logic [7:0]  d;
	logic [15:0] c;
	logic [7:0]  q[$];
	int          fail_count;
	int          total_checks;
	int          sent;

	scf_framer #(.BIT_DIV(2), .HD(8)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .cts_n(cts_n),
		.carrier_detect_input_n(cd_n), .rts_n(rts_n)
	);
	scf_station #(.BIT_DIV(2)) st (
		.sys_clk(sys_clk), .rts_n(rts_n), .halt(halt), .rxd(rxd), .cts_n(cts_n)
	);

	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Line monitor, one sample per bit
	// ----------------------------------------
	always @(posedge sys_clk) begin
		ph <= ~ph;
		if (ph) begin
			win <= {txd, win[23:1]};
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			give_verdict();
		end
	endtask

	task automatic wait_win(input logic [23:0] pat, input int lim);
		hit = 1'b0;
		for (int n = 0; n < lim && !hit; n++) begin
			@(posedge sys_clk);
			hit = (win === pat);
		end
	endtask

	function automatic logic pbit(input logic [6:0] v, input int m);
		case (m)
			0: return ^v;
			1: return ~^v;
			2: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [15:0] crc8(input logic [7:0] v, input logic [15:0] p,
		input logic [15:0] c);
		for (int i = 0; i < 8; i++) begin
			c = (c >> 1) ^ ((c[0] ^ v[i]) ? p : 16'h0000);
		end
		return c;
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		cd_n = 1'b0;
		halt = 1'b0;
		ph = 1'b0;
		win = '1;
		fail_count = 0;
		total_checks = 0;
		void'($urandom(32'hb0c5));
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1);
		$display("test unmapped done");

		apb(1'b1, `SCF_A_SYNC, 32'h0000_0016);
		apb(1'b1, `SCF_A_CTRL, 32'h0000_0709);
		apb(1'b1, `SCF_A_CMD, 32'h0000_0001);
		repeat (8) @(posedge sys_clk);
		chk(rts_n, 1'b0);
		st.send_char(8'h16, s);
		sent = 0;
		s = 1'b1;
		for (int k = 0; k < 64 && s; k++) begin
			d = 8'($urandom());
			if (k == 5) d = 8'h16;
			st.send_char(d, s);
			if (s && d != 8'h16) begin
				q.push_back(d);
				sent++;
			end
		end
		repeat (8) @(posedge sys_clk);
		chk(rts_n, 1'b1);
		chk(32'(sent == 36 || sent == 37), 1);
		apb(1'b1, `SCF_A_CTRL, 32'h0000_0708);
		apb(1'b0, `SCF_A_RXD, 32'h0);
		for (int k = 0; k < 64 && rd[8] !== 1'b1; k++) begin
			chk(rd[7:0], q.pop_front());
			apb(1'b0, `SCF_A_RXD, 32'h0);
		end
		chk(32'(q.size()), 0);
		apb(1'b0, `SCF_A_STAT, 32'h0);
		chk(rd[2:0], 3'h1);
		chk(rts_n, 1'b0);
		$display("test receive flow done");

		for (int i = 0; i < 4; i++) begin
			repeat (60) @(posedge sys_clk);
			halt <= (i < 2);
			d = 8'($urandom());
			apb(1'b1, `SCF_A_CTRL, 32'h0001_0620 | (i << 6) | ((i == 1) ? 4 : 0));
			apb(1'b1, `SCF_A_TXD, {24'h0, d});
			apb(1'b1, `SCF_A_CMD, 32'h0000_0004);
			apb(1'b1, `SCF_A_CMD, 32'h0000_0008);
			if (i == 0) begin
				wait_win({pbit(d[6:0], i), d[6:0], 8'h16, 8'hff}, 100);
				chk(hit, 1'b0);
				chk(txd, 1'b1);
				halt <= 1'b0;
			end
			wait_win({pbit(d[6:0], i), d[6:0], 8'h16, 8'hff}, 400);
			chk(hit, 1'b1);
		end
		$display("test transmit parity done");

		apb(1'b1, `SCF_A_SYNC, 32'h005a_0016);
		for (int j = 0; j < 2; j++) begin
			repeat (60) @(posedge sys_clk);
			d = 8'($urandom());
			apb(1'b1, `SCF_A_CTRL, 32'h0007_2700 | (j << 14) | (j << 15));
			apb(1'b1, `SCF_A_TXD, {24'h0, d});
			apb(1'b1, `SCF_A_CMD, 32'h0000_0004);
			apb(1'b1, `SCF_A_CMD, 32'h0000_0008);
			wait_win({8'h16, 8'h5a, 8'hff}, 400);
			chk(hit, 1'b1);
			wait_win({crc8(d, j ? 16'h8408 : 16'ha001, j ? 16'hffff : 16'h0000), d}, 200);
			chk(hit, 1'b1);
		end
		$display("test crc preamble done");

		d = 8'($urandom());
		c = crc8(d, 16'ha001, 16'h0000);
		apb(1'b1, `SCF_A_CTRL, 32'h0000_2700);
		apb(1'b1, `SCF_A_CMD, 32'h0000_0004);
		repeat (60) @(posedge sys_clk);
		apb(1'b1, `SCF_A_TXD, {24'h0, d});
		apb(1'b1, `SCF_A_CMD, 32'h0000_0008);
		wait_win({c, d}, 200);
		chk(hit, 1'b1);
		wait_win({8'h16, c}, 100);
		chk(hit, 1'b1);
		apb(1'b0, `SCF_A_STAT, 32'h0);
		chk(rd[1], 1'b1);
		apb(1'b1, `SCF_A_STAT, 32'h0000_0002);
		apb(1'b0, `SCF_A_STAT, 32'h0);
		chk(rd[1], 1'b0);
		$display("test underrun fill done");

		apb(1'b1, `SCF_A_SYNC, 32'h0000_6916);
		apb(1'b1, `SCF_A_XCHR, 32'h0000_1311);
		apb(1'b1, `SCF_A_CTRL, 32'h0001_0f13);
		apb(1'b1, `SCF_A_CMD, 32'h0000_0001);
		st.send_char(8'h16, s);
		st.send_char(8'h69, s);
		st.send_char(8'h13, s);
		repeat (20) @(posedge sys_clk);
		apb(1'b0, `SCF_A_STAT, 32'h0);
		chk(rd[4], 1'b0);
		d = 8'($urandom());
		apb(1'b1, `SCF_A_TXD, {24'h0, d});
		apb(1'b1, `SCF_A_CMD, 32'h0000_0004);
		apb(1'b1, `SCF_A_CMD, 32'h0000_0008);
		wait_win({d, 8'h69, 8'h16}, 200);
		chk(hit, 1'b0);
		apb(1'b1, `SCF_A_CMD, 32'h0000_0001);
		st.send_char(8'h16, s);
		st.send_char(8'h69, s);
		st.send_char(8'h11, s);
		wait_win({d, 8'h69, 8'h16}, 400);
		chk(hit, 1'b1);
		apb(1'b1, `SCF_A_CMD, 32'h0000_0002);
		apb(1'b0, `SCF_A_STAT, 32'h0);
		chk(rd[14:9], 6'h01);
		$display("test inband flow done");
		give_verdict();
	end
endmodule
